// >>> cpu_bus_pkg.sv
// constants and types of the multiplexed bus cycle sequencer
`default_nettype none

package cpu_bus_pkg;

    localparam int REG_AW      = 3;
    localparam int REG_DW      = 32;
    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 16;
    localparam int QUEUE_WORDS = 3;   // six bytes as three bus words
    localparam int QPTR_W      = 2;

    // register offsets (word index on the register port)
    localparam logic [2:0] REG_CONFIG = 3'h0;
    localparam logic [2:0] REG_ADDR   = 3'h1;
    localparam logic [2:0] REG_WDATA  = 3'h2;
    localparam logic [2:0] REG_CMD    = 3'h3;
    localparam logic [2:0] REG_RDATA  = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    localparam logic [2:0] REG_QUEUE  = 3'h6;
    localparam logic [2:0] REG_JUMP   = 3'h7;

    // field positions
    localparam int CFG_IF_BIT   = 0;
    localparam int CFG_MAX_BIT  = 1;
    localparam int CFG_PF_BIT   = 2;
    localparam int CMD_KIND_LSB = 0;
    localparam int CMD_SEG_LSB  = 3;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_PEND_BIT  = 1;
    localparam int ST_DONE_BIT  = 2;
    localparam int ST_QCNT_LSB  = 4;
    localparam int ST_STATE_LSB = 8;
    localparam int QUEUE_VALID_BIT = 16;

    // values after reset, and the fetch address step
    localparam logic [2:0]  CFG_RST   = 3'h4;
    localparam logic [19:0] FETCH_RST = 20'h00000;
    localparam logic [19:0] FETCH_STEP = 20'h00002;

    typedef enum logic [2:0] {
        bus_idle_state      = 3'b000,
        first_cycle_state   = 3'b001,
        second_cycle_state  = 3'b010,
        third_cycle_state   = 3'b011,
        inserted_wait_state = 3'b100,
        final_cycle_state   = 3'b101
    } bus_state_t;

    typedef enum logic [2:0] {
        KIND_MEM_RD = 3'b000,
        KIND_MEM_WR = 3'b001,
        KIND_IO_RD  = 3'b010,
        KIND_IO_WR  = 3'b011,
        KIND_INTA   = 3'b100,
        KIND_FETCH  = 3'b101
    } cycle_kind_t;

    // {segment_status_high, segment_status_low}
    typedef enum logic [1:0] {
        SEG_EXTRA = 2'b00,
        SEG_STACK = 2'b01,
        SEG_CODE  = 2'b10,
        SEG_DATA  = 2'b11
    } segment_t;

endpackage

`default_nettype wire

// >>> prefetch_queue.sv
// instruction prefetch queue, three words with registered head
`default_nettype none

module prefetch_queue (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic                          flush,
    input  wire logic                          push,
    input  wire logic [cpu_bus_pkg::DATA_W-1:0] push_data,
    input  wire logic                          pop,
    output var  logic [cpu_bus_pkg::DATA_W-1:0] head_r,
    output var  logic [1:0]                    count_r
);
    import cpu_bus_pkg::*;

    logic [DATA_W-1:0] mem [QUEUE_WORDS];
    logic [QPTR_W-1:0] wr_ptr_r;
    logic [QPTR_W-1:0] rd_ptr_r;
    logic [QPTR_W-1:0] rd_nxt;
    logic              pop_ok;
    logic              push_ok;

    function automatic logic [QPTR_W-1:0] inc(input logic [QPTR_W-1:0] p);
        inc = (p == QPTR_W'(QUEUE_WORDS - 1)) ? '0 : p + 1'b1;
    endfunction

    assign pop_ok  = pop && (count_r != 2'd0);
    assign push_ok = push && (count_r != 2'(QUEUE_WORDS) || pop_ok);
    assign rd_nxt  = pop_ok ? inc(rd_ptr_r) : rd_ptr_r;

    genvar i;
    generate
        for (i = 0; i < QUEUE_WORDS; i++) begin : g_entry
            always_ff @(posedge clk_sys) begin
                if (push_ok && !flush && wr_ptr_r == QPTR_W'(i)) begin
                    mem[i] <= push_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= 2'd0;
        end else begin
            rd_ptr_r <= rd_nxt;
            if (push_ok) begin
                wr_ptr_r <= inc(wr_ptr_r);
            end
            count_r <= count_r + 2'(push_ok) - 2'(pop_ok);
        end
    end

    // write-through keeps the head correct right after a push
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            head_r <= '0;
        end else if (push_ok && wr_ptr_r == rd_nxt) begin
            head_r <= push_data;
        end else begin
            head_r <= mem[rd_nxt];
        end
    end

endmodule

`default_nettype wire

// >>> cpu_bus_cycle.sv
// bus cycle sequencer for the multiplexed address/status/data bus
//
// The register offsets and strobed register access were decided locally.
`default_nettype none

module cpu_bus_cycle (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic [cpu_bus_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [cpu_bus_pkg::REG_DW-1:0] reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output var  logic [cpu_bus_pkg::REG_DW-1:0] reg_rdata,
    input  wire logic                          bus_ready,
    input  wire logic [cpu_bus_pkg::DATA_W-1:0] ad_in,
    output var  logic [cpu_bus_pkg::DATA_W-1:0] ad_out,
    output var  logic                          ad_oe,
    output var  logic [3:0]                    addr_status_out,
    output var  logic                          addr_latch_strobe,
    output var  logic                          rd_n,
    output var  logic                          wr_n,
    output var  logic                          inta_n,
    output var  logic                          delayed_wr_n,
    output var  logic                          mem_not_io,
    output var  logic                          xcvr_transmit,
    output var  logic                          xcvr_en_n
);
    import cpu_bus_pkg::*;

    bus_state_t        state_r;
    bus_state_t        state_nxt;
    logic [2:0]        cfg_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    cycle_kind_t       kind_r;
    segment_t          seg_r;
    logic              pend_r;
    logic              done_r;
    logic [DATA_W-1:0] rdata_cap_r;
    logic [ADDR_W-1:0] fetch_addr_r;
    cycle_kind_t       cyc_kind_r;
    segment_t          cyc_seg_r;
    logic [ADDR_W-1:0] cyc_addr_r;
    logic [DATA_W-1:0] cyc_wdata_r;
    logic              cyc_stale_r;

    logic              wr_cfg;
    logic              wr_cmd;
    logic              wr_jump;
    logic              rd_queue;
    logic              at_boundary;
    logic              start_op;
    logic              start_fetch;
    logic              go;
    logic              capture;
    cycle_kind_t       nk;
    segment_t          nseg;
    logic [ADDR_W-1:0] naddr;
    logic [DATA_W-1:0] nwdata;
    logic              n_write;
    logic              n_io;
    logic              n_rdstb;
    logic              q_push;
    logic              q_pop;
    logic [DATA_W-1:0] q_head;
    logic [1:0]        q_count;
    logic              if_flag;
    logic              max_mode;

    assign if_flag  = cfg_r[CFG_IF_BIT];
    assign max_mode = cfg_r[CFG_MAX_BIT];
    assign wr_cfg   = reg_wr && reg_addr == REG_CONFIG;
    assign wr_cmd   = reg_wr && reg_addr == REG_CMD;
    assign wr_jump  = reg_wr && reg_addr == REG_JUMP;
    assign rd_queue = reg_rd && reg_addr == REG_QUEUE;

    // a new cycle may begin from idle or straight after a final state
    assign at_boundary = state_r == bus_idle_state
                      || state_r == final_cycle_state;
    assign start_op    = pend_r;
    assign start_fetch = !pend_r && cfg_r[CFG_PF_BIT] && !wr_jump
                      && q_count < 2'(QUEUE_WORDS);
    assign go          = at_boundary && (start_op || start_fetch);

    // data sampled on the edge that ends the last third or wait state
    assign capture = (state_r == third_cycle_state
                   || state_r == inserted_wait_state)
                  && bus_ready;

    // cycle attributes as seen from the next state onward
    always_comb begin
        nk     = cyc_kind_r;
        nseg   = cyc_seg_r;
        naddr  = cyc_addr_r;
        nwdata = cyc_wdata_r;
        if (go && start_op) begin
            nk     = kind_r;
            nseg   = seg_r;
            naddr  = addr_r;
            nwdata = wdata_r;
        end else if (go) begin
            nk     = KIND_FETCH;
            nseg   = SEG_CODE;
            naddr  = fetch_addr_r;
            nwdata = cyc_wdata_r;
        end
    end

    assign n_write = nk == KIND_MEM_WR || nk == KIND_IO_WR;
    assign n_io    = nk == KIND_IO_RD || nk == KIND_IO_WR;
    assign n_rdstb = nk == KIND_MEM_RD || nk == KIND_IO_RD
                  || nk == KIND_FETCH;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            bus_idle_state: begin
                if (go) begin
                    state_nxt = first_cycle_state;
                end
            end
            first_cycle_state: begin
                state_nxt = second_cycle_state;
            end
            second_cycle_state: begin
                state_nxt = third_cycle_state;
            end
            third_cycle_state, inserted_wait_state: begin
                // not-ready holds the cycle in wait states
                state_nxt = bus_ready ? final_cycle_state
                                      : inserted_wait_state;
            end
            final_cycle_state: begin
                state_nxt = go ? first_cycle_state : bus_idle_state;
            end
            default: begin
                state_nxt = bus_idle_state;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= bus_idle_state;
        end else begin
            state_r <= state_nxt;
        end
    end

    // software registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_r   <= CFG_RST;
            addr_r  <= '0;
            wdata_r <= '0;
        end else if (reg_wr) begin
            if (wr_cfg) begin
                cfg_r <= reg_wdata[2:0];
            end
            if (reg_addr == REG_ADDR) begin
                addr_r <= reg_wdata[ADDR_W-1:0];
            end
            if (reg_addr == REG_WDATA) begin
                wdata_r <= reg_wdata[DATA_W-1:0];
            end
        end
    end

    // one pending operand request; a command while pending is dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pend_r <= 1'b0;
            kind_r <= KIND_MEM_RD;
            seg_r  <= SEG_DATA;
        end else if (wr_cmd && !pend_r) begin
            pend_r <= 1'b1;
            kind_r <= cycle_kind_t'(reg_wdata[CMD_KIND_LSB +: 3]);
            seg_r  <= segment_t'(reg_wdata[CMD_SEG_LSB +: 2]);
        end else if (go && start_op) begin
            pend_r <= 1'b0;
        end
    end

    // done flag: cleared by a new command, but a finishing cycle wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            done_r <= 1'b0;
        end else if (state_r == final_cycle_state
                  && cyc_kind_r != KIND_FETCH) begin
            done_r <= 1'b1;
        end else if (wr_cmd && !pend_r) begin
            done_r <= 1'b0;
        end
    end

    // latched cycle attributes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cyc_kind_r  <= KIND_FETCH;
            cyc_seg_r   <= SEG_CODE;
            cyc_addr_r  <= '0;
            cyc_wdata_r <= '0;
        end else if (go) begin
            cyc_kind_r  <= nk;
            cyc_seg_r   <= nseg;
            cyc_addr_r  <= naddr;
            cyc_wdata_r <= nwdata;
        end
    end

    // fetch pointer and discard of a fetch in flight
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fetch_addr_r <= FETCH_RST;
            cyc_stale_r  <= 1'b0;
        end else if (wr_jump) begin
            fetch_addr_r <= reg_wdata[ADDR_W-1:0];
            cyc_stale_r  <= state_r != bus_idle_state
                         && cyc_kind_r == KIND_FETCH;
        end else if (go) begin
            cyc_stale_r <= 1'b0;
            if (!start_op) begin
                fetch_addr_r <= fetch_addr_r + FETCH_STEP;
            end
        end
    end

    // read capture for operand and acknowledge cycles
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_cap_r <= '0;
        end else if (capture && cyc_kind_r != KIND_FETCH
                  && cyc_kind_r != KIND_MEM_WR
                  && cyc_kind_r != KIND_IO_WR) begin
            rdata_cap_r <= ad_in;
        end
    end

    assign q_push = capture && cyc_kind_r == KIND_FETCH
                 && !cyc_stale_r && !wr_jump;
    assign q_pop  = rd_queue;

    prefetch_queue u_queue (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .flush     (wr_jump),
        .push      (q_push),
        .push_data (ad_in),
        .pop       (q_pop),
        .head_r    (q_head),
        .count_r   (q_count)
    );

    // register read data, valid the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            case (reg_addr)
                REG_CONFIG: reg_rdata[2:0] <= cfg_r;
                REG_ADDR:   reg_rdata[ADDR_W-1:0] <= addr_r;
                REG_WDATA:  reg_rdata[DATA_W-1:0] <= wdata_r;
                REG_CMD: begin
                    reg_rdata[CMD_KIND_LSB +: 3] <= kind_r;
                    reg_rdata[CMD_SEG_LSB +: 2]  <= seg_r;
                end
                REG_RDATA:  reg_rdata[DATA_W-1:0] <= rdata_cap_r;
                REG_STATUS: begin
                    reg_rdata[ST_BUSY_BIT] <= state_r != bus_idle_state;
                    reg_rdata[ST_PEND_BIT] <= pend_r;
                    reg_rdata[ST_DONE_BIT] <= done_r;
                    reg_rdata[ST_QCNT_LSB +: 2]  <= q_count;
                    reg_rdata[ST_STATE_LSB +: 3] <= state_r;
                end
                REG_QUEUE: begin
                    reg_rdata[DATA_W-1:0]     <= q_head;
                    reg_rdata[QUEUE_VALID_BIT] <= q_count != 2'd0;
                end
                REG_JUMP:   reg_rdata[ADDR_W-1:0] <= fetch_addr_r;
                default:    reg_rdata <= '0;
            endcase
        end
    end

    // pins, set on the edge that enters each state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ad_out            <= '0;
            ad_oe             <= 1'b0;
            addr_status_out   <= 4'h0;
            addr_latch_strobe <= 1'b0;
            rd_n              <= 1'b1;
            wr_n              <= 1'b1;
            inta_n            <= 1'b1;
            delayed_wr_n      <= 1'b1;
            mem_not_io        <= 1'b1;
            xcvr_transmit     <= 1'b0;
            xcvr_en_n         <= 1'b1;
        end else begin
            case (state_nxt)
                first_cycle_state: begin
                    addr_latch_strobe <= 1'b1;
                    ad_out <= naddr[DATA_W-1:0];
                    ad_oe  <= 1'b1;
                    // io space has only sixteen address bits
                    addr_status_out <= n_io ? 4'h0
                                            : naddr[19:16];
                    mem_not_io    <= !n_io;
                    xcvr_transmit <= n_write;
                    // outbound data may open the transceiver at once
                    xcvr_en_n <= !(n_write && !max_mode);
                end
                second_cycle_state: begin
                    addr_latch_strobe <= 1'b0;
                    ad_out <= n_write ? nwdata : ad_out;
                    ad_oe  <= n_write;
                    addr_status_out <= {1'b0, if_flag,
                                        nseg[1], nseg[0]};
                    rd_n   <= !n_rdstb;
                    wr_n   <= !n_write;
                    inta_n <= nk != KIND_INTA;
                    xcvr_en_n <= 1'b0;
                end
                third_cycle_state, inserted_wait_state: begin
                    // status and data lines hold their second-state values
                    delayed_wr_n <= !(n_write && max_mode);
                end
                final_cycle_state: begin
                    rd_n         <= 1'b1;
                    wr_n         <= 1'b1;
                    inta_n       <= 1'b1;
                    delayed_wr_n <= 1'b1;
                    xcvr_en_n    <= 1'b1;
                end
                bus_idle_state: begin
                    // status and write data stay; a read left the bus off
                    ad_oe <= ad_oe && xcvr_transmit;
                end
                default: begin
                    ad_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> bus_cycle_properties.sv
// assertion checker watching the bus cycle sequencer ports
`default_nettype none

module bus_cycle_checker (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       bus_ready,
    input wire logic       ad_oe,
    input wire logic [3:0] addr_status_out,
    input wire logic       addr_latch_strobe,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       inta_n,
    input wire logic       delayed_wr_n,
    input wire logic       xcvr_en_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic no_cmd;
    assign no_cmd = rd_n && wr_n && inta_n;

    four_states_a: assert property (
        addr_latch_strobe |=> !addr_latch_strobe [*3])
        else $error("cycle shorter than four states");
    strobe_second_a: assert property (
        addr_latch_strobe |-> no_cmd ##1 !no_cmd)
        else $error("command not started in second state");
    addr_drive_a: assert property (
        addr_latch_strobe |-> ad_oe)
        else $error("address not driven in first state");
    owner_zero_a: assert property (
        !addr_latch_strobe |-> !addr_status_out[3])
        else $error("bus owner status not zero");
    read_float_a: assert property (
        (!rd_n || !inta_n) |-> !ad_oe)
        else $error("lower lines driven during read");
    delayed_write_a: assert property (
        !delayed_wr_n |-> !wr_n && $past(!wr_n))
        else $error("delayed write outside third state");
    wait_hold_a: assert property (
        (!no_cmd && $past(!no_cmd) && !bus_ready) |=> !no_cmd)
        else $error("command ended while not ready");
    ready_end_a: assert property (
        (!no_cmd && $past(!no_cmd) && bus_ready) |=> no_cmd)
        else $error("command not ended in final state");
    status_hold_a: assert property (
        (!no_cmd && $past(!no_cmd)) |-> $stable(addr_status_out))
        else $error("status changed in third or wait state");
    read_release_a: assert property (
        $rose(rd_n) |-> !ad_oe)
        else $error("lines driven after read");
    write_keep_a: assert property (
        $rose(wr_n) |-> ad_oe ##1 ad_oe)
        else $error("write data dropped after write");
    xcvr_second_a: assert property (
        addr_latch_strobe |=> !xcvr_en_n)
        else $error("transceivers off in second state");

    cover property (!no_cmd && $past(!no_cmd) && !bus_ready);
    cover property (!delayed_wr_n);
    cover property ($rose(rd_n) ##1 addr_latch_strobe);
endmodule

bind cpu_bus_cycle bus_cycle_checker checker_inst (
    .clk_sys(clk_sys), .reset(reset), .bus_ready(bus_ready),
    .ad_oe(ad_oe), .addr_status_out(addr_status_out),
    .addr_latch_strobe(addr_latch_strobe), .rd_n(rd_n), .wr_n(wr_n),
    .inta_n(inta_n), .delayed_wr_n(delayed_wr_n), .xcvr_en_n(xcvr_en_n)
);

`default_nettype wire

// >>> mem_io_model.sv
// behavioural memory and io device behind the address latch
`default_nettype none

module mem_io_model #(
    parameter logic [15:0] INTA_VECTOR = 16'h0023
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        lat_oe_n,
    input  wire logic [1:0]  wait_count,
    input  wire logic        ad_oe,
    input  wire logic [15:0] ad_out,
    input  wire logic [3:0]  addr_status_out,
    input  wire logic        addr_latch_strobe,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        inta_n,
    input  wire logic        mem_not_io,
    output var  logic [15:0] ad_in,
    output var  logic        bus_ready,
    output var  logic [19:0] lat_addr_r,
    output var  logic        lat_mem_r,
    output var  logic [3:0]  status_seen_r,
    output var  logic [7:0]  strobe_len_r
);
    logic [15:0] mem_r [32];
    logic [15:0] last_r;
    logic        wr_q_r;
    logic        second_r;
    logic [4:0]  idx;

    assign idx = {lat_mem_r, lat_addr_r[4:1]};
    // not ready from second state until wait_count waits have passed
    assign bus_ready = strobe_len_r > 8'(wait_count);

    always_comb begin
        if (ad_oe)
            ad_in = ad_out;
        // devices see an address only while the latch drives it
        else if (!rd_n && !lat_oe_n)
            ad_in = mem_r[idx];
        else if (!inta_n)
            ad_in = INTA_VECTOR;
        else
            ad_in = ~last_r; // released lines wander
    end

    always_ff @(posedge clk_sys) begin
        last_r <= ad_in;
        if (reset) begin
            for (int j = 0; j < 32; j++)
                mem_r[j] <= 16'hc000 + 16'(j);
            strobe_len_r <= 8'h00;
            wr_q_r <= 1'b1;
            second_r <= 1'b0;
        end else begin
            wr_q_r <= wr_n;
            second_r <= addr_latch_strobe;
            if (addr_latch_strobe) begin
                lat_addr_r <= {addr_status_out, ad_out};
                lat_mem_r <= mem_not_io;
                strobe_len_r <= 8'h00;
            end else if (!(rd_n && wr_n && inta_n))
                strobe_len_r <= strobe_len_r + 8'h01;
            if (second_r)
                status_seen_r <= addr_status_out;
            if (wr_n && !wr_q_r && !lat_oe_n)
                mem_r[idx] <= ad_in;
        end
    end
endmodule

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the bus cycle sequencer
`default_nettype none

module tb_top import cpu_bus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [15:0] INTA_VEC = 16'h0023;
    logic              clk_sys, reset, reg_wr, reg_rd, bus_ready;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata, reg_rdata;
    logic [15:0]       ad_in, ad_out;
    logic [3:0]        addr_status_out, status_seen;
    logic              ad_oe, addr_latch_strobe, rd_n, wr_n, inta_n;
    logic              delayed_wr_n, mem_not_io, xcvr_transmit, xcvr_en_n;
    logic [1:0]        wait_count;
    logic [19:0]       lat_addr;
    logic              lat_mem;
    logic [7:0]        strobe_len;
    int                fail_count = 0;
    int                samples_checked = 0;
    int                kinds[5] = '{1, 0, 3, 2, 4};

    cpu_bus_cycle cpu_bus_cycle_inst (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_ready(bus_ready), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe(ad_oe), .addr_status_out(addr_status_out),
        .addr_latch_strobe(addr_latch_strobe), .rd_n(rd_n), .wr_n(wr_n),
        .inta_n(inta_n), .delayed_wr_n(delayed_wr_n),
        .mem_not_io(mem_not_io), .xcvr_transmit(xcvr_transmit),
        .xcvr_en_n(xcvr_en_n));

    mem_io_model #(.INTA_VECTOR(INTA_VEC)) mem_io_model_inst (
        .clk_sys(clk_sys), .reset(reset), .wait_count(wait_count),
        .lat_oe_n(reset),
        .ad_oe(ad_oe), .ad_out(ad_out), .addr_status_out(addr_status_out),
        .addr_latch_strobe(addr_latch_strobe), .rd_n(rd_n), .wr_n(wr_n),
        .inta_n(inta_n), .mem_not_io(mem_not_io), .ad_in(ad_in),
        .bus_ready(bus_ready), .lat_addr_r(lat_addr), .lat_mem_r(lat_mem),
        .status_seen_r(status_seen), .strobe_len_r(strobe_len));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic wait_done();
        logic [31:0] st;
        st = '0;
        for (int n = 0; n < 40 && !st[ST_DONE_BIT]; n++)
            reg_read(REG_STATUS, st);
        check("cycle done", 32'(st[ST_DONE_BIT]), 32'h1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end

    initial begin
        logic [31:0] d, rexp;
        logic [19:0] a, aexp;
        logic [15:0] wd;
        logic [3:0]  sexp;
        int          k;
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        wait_count = 2'h0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        reg_read(REG_CONFIG, d);
        check("config reset", d, 32'(CFG_RST));
        repeat (30) @(posedge clk_sys);
        reg_read(REG_STATUS, d);
        check("queue words", 32'(d[ST_QCNT_LSB+:2]), 32'h3);
        for (int i = 0; i < 3; i++) begin
            reg_read(REG_QUEUE, d);
            check("queue head", d, 32'h1c010 + 32'(i));
        end
        reg_write(REG_JUMP, 32'h00010);
        reg_read(REG_STATUS, d);
        check("queue flush", 32'(d[ST_QCNT_LSB+:2]), 32'h0);
        repeat (20) @(posedge clk_sys);
        reg_read(REG_QUEUE, d);
        check("jump target", d, 32'h1c018);
        reg_write(REG_CONFIG, 32'h1);
        repeat (10) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            k = kinds[i % 5];
            if (i == 5)
                reg_write(REG_CONFIG, 32'h2); // flag off, max mode
            a = 20'hb3a40 + 20'(i / 5 * 2);
            aexp = k < 2 ? a : {4'h0, a[15:0]};
            wd = 16'h5a00 + 16'(i);
            sexp = {1'b0, i < 5, 2'(i)};
            rexp = k == 4 ? 32'(INTA_VEC) : 32'h5a00 + 32'(i - 1);
            reg_write(REG_ADDR, 32'(a));
            wait_count <= 2'(i);
            reg_write(REG_WDATA, 32'(wd));
            reg_write(REG_CMD, 32'(k) | 32'(i % 4) << CMD_SEG_LSB);
            wait_done();
            check("cycle status", 32'(status_seen), 32'(sexp));
            check("strobe length", 32'(strobe_len), 32'(2 + i % 4));
            check("idle status", 32'(addr_status_out), 32'(sexp));
            check("idle drive", 32'(ad_oe), 32'(k == 1 || k == 3));
            check("xcvr dir", 32'(xcvr_transmit), 32'(k % 2));
            if (k < 4)
                check("latched addr", 32'(lat_addr), 32'(aexp));
            if (k < 4)
                check("space select", 32'(lat_mem), 32'(k < 2));
            if (k == 1 || k == 3)
                check("idle data", 32'(ad_out), 32'(wd));
            if (k == 0 || k == 2 || k == 4) begin
                reg_read(REG_RDATA, d);
                check("read data", d, rexp);
            end
        end
        complete_run();
    end
endmodule

`default_nettype wire
